// file: src/fwbp_top.sv
// Flash command sequencer for single word and write buffer programming, AHB-Lite reached.
`timescale 1ns/1ps
module fwbp_top
	import fwbp_pkg::*;
#(
	parameter int AW         = ARR_AW,
	parameter int SECT_LO    = SECT_LSB,
	parameter int PROG_CYC_P = PROG_CYC
) (
	input  logic        core_clk,
	input  logic        rst_n,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic [31:0] hrdata,
	output logic        hreadyout,
	output logic        hresp
);

	// ****************************************************************
	// State of the sequencer
	// ****************************************************************

	typedef struct packed {
		fwbp_state_e               st;
		logic [AW-1:0]             cmdAddr;
		logic [15:0]               cmdData;
		logic [AW-1:0]             rdAddr;
		logic [AW-1:0]             latAddr;
		logic [15:0]               latData;
		logic                      isBuf;
		logic                      ovfAbort;
		logic [AW-1:SECT_LO]       sector;
		logic [AW-1:PAGE_LSB]      page;
		logic                      started;
		logic [5:0]                remain;
		logic [BUF_WORDS-1:0][15:0] bufData;
		logic [BUF_WORDS-1:0]      bufValid;
		logic [15:0]               timer;
		logic                      toggle;
	} fwbp_core_s;

	fwbp_core_s    s_r;
	fwbp_core_s    s_nxt;
	fwbp_reg_if    regs ();
	logic          cmdWr;
	logic [AW-1:0] wAddr;
	logic [15:0]   wData;
	logic          progEn;
	logic          commitEn;
	logic [15:0]   arrData;
	logic          showStatus;
	logic [15:0]   statusWord;
	logic [31:0]   blockStatus;

	localparam logic [15:0] PROG_LOAD = 16'(PROG_CYC_P);

	// ****************************************************************
	// Address decode helpers
	// ****************************************************************

	// True when the word address sits at the given offset from the base.
	function automatic logic atOff(input logic [AW-1:0] a, input logic [10:0] off);
		atOff = (a[10:0] == off);
	endfunction

	// True when a command word with the given data lands at the given offset.
	function automatic logic isCmd(input logic [AW-1:0] a, input logic [15:0] d,
		input logic [15:0] cmd, input logic [10:0] off);
		isCmd = (d == cmd) && atOff(a, off);
	endfunction

	// True when the word address lies in the sector chosen by the buffer load.
	function automatic logic inSector(input logic [AW-1:0] a,
		input logic [AW-1:SECT_LO] sect);
		inSector = (a[AW-1:SECT_LO] == sect);
	endfunction

	// True when the word address lies in the buffer page fixed by the first load.
	function automatic logic inPage(input logic [AW-1:0] a,
		input logic [AW-1:PAGE_LSB] pg);
		inPage = (a[AW-1:PAGE_LSB] == pg);
	endfunction

	// ****************************************************************
	// Bus slave and array
	// ****************************************************************

	fwbp_ahb_slave u_slave (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.regs      (regs.slave)
	);

	fwbp_array #(
		.AW (AW)
	) u_array (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.rdAddr     (s_r.rdAddr),
		.rdData     (arrData),
		.progEn     (progEn),
		.progAddr   (s_r.latAddr),
		.progData   (s_r.latData),
		.commitEn   (commitEn),
		.commitPage (s_r.page),
		.bufData    (s_r.bufData),
		.bufValid   (s_r.bufValid)
	);

	// A write of the command data register issues one flash write cycle.
	assign cmdWr = regs.wrEn && (regs.wIdx == REG_CMD_DATA);
	assign wAddr = s_r.cmdAddr;
	assign wData = regs.wdata[15:0];

	// ****************************************************************
	// Command sequencer
	// ****************************************************************

	// Walks the unlock, setup, load and confirm cycles and runs the program timer.
	always_comb begin
		s_nxt = s_r;
		progEn = 1'b0;
		commitEn = 1'b0;
		if (regs.wrEn && (regs.wIdx == REG_CMD_ADDR)) begin
			s_nxt.cmdAddr = regs.wdata[AW-1:0];
		end
		if (regs.wrEn && (regs.wIdx == REG_RD_ADDR)) begin
			s_nxt.rdAddr = regs.wdata[AW-1:0];
		end
		if (cmdWr) begin
			s_nxt.cmdData = wData;
		end
		// Each status read flips the toggle bit while the device shows status.
		if (regs.rdEn && (regs.rIdx == REG_RD_DATA) && showStatus) begin
			s_nxt.toggle = ~s_r.toggle;
		end
		case (s_r.st)
			// Array read mode waits for the first unlock write.
			ST_READ: begin
				if (cmdWr && isCmd(wAddr, wData, CMD_UNLOCK1, OFF_UNLOCK1)) begin
					s_nxt.st = ST_UNLK1;
				end
			end
			// A wrong second unlock write falls back to read mode.
			ST_UNLK1: begin
				if (cmdWr) begin
					if (isCmd(wAddr, wData, CMD_UNLOCK2, OFF_UNLOCK2)) begin
						s_nxt.st = ST_UNLK2;
					end else begin
						s_nxt.st = ST_READ;
					end
				end
			end
			// The third cycle picks word program or the buffer load of a sector.
			ST_UNLK2: begin
				if (cmdWr) begin
					if (isCmd(wAddr, wData, CMD_PROG, OFF_UNLOCK1)) begin
						s_nxt.st = ST_PSETUP;
					end else if (wData == CMD_BUFLOAD) begin
						s_nxt.sector = wAddr[AW-1:SECT_LO];
						s_nxt.st = ST_BCOUNT;
					end else begin
						s_nxt.st = ST_READ;
					end
				end
			end
			ST_PSETUP: begin
				// The fourth cycle latches the target and starts the program.
				if (cmdWr) begin
					s_nxt.latAddr = wAddr;
					s_nxt.latData = wData;
					s_nxt.isBuf = 1'b0;
					s_nxt.timer = PROG_LOAD;
					s_nxt.st = ST_BUSY;
				end
			end
			// The count cycle must stay in the sector and fit the buffer.
			ST_BCOUNT: begin
				if (cmdWr) begin
					if (!inSector(wAddr, s_r.sector)) begin
						s_nxt.st = ST_ABORT;
					end else if (wData > 16'(BUF_WORDS - 1)) begin
						s_nxt.ovfAbort = 1'b1;
						s_nxt.st = ST_ABORT;
					end else begin
						s_nxt.remain = {1'b0, wData[4:0]} + 6'h01;
						s_nxt.started = 1'b0;
						s_nxt.bufValid = '0;
						s_nxt.st = ST_BLOAD;
					end
				end
			end
			// Each load must stay in the sector and in the page of the first load.
			ST_BLOAD: begin
				if (cmdWr) begin
					if (!inSector(wAddr, s_r.sector)) begin
						s_nxt.st = ST_ABORT;
					end else if (s_r.started && !inPage(wAddr, s_r.page)) begin
						s_nxt.st = ST_ABORT;
					end else begin
						// The first load fixes the page; later loads overwrite freely.
						if (!s_r.started) begin
							s_nxt.page = wAddr[AW-1:PAGE_LSB];
						end
						s_nxt.started = 1'b1;
						s_nxt.bufData[wAddr[PAGE_LSB-1:0]] = wData;
						s_nxt.bufValid[wAddr[PAGE_LSB-1:0]] = 1'b1;
						s_nxt.latAddr = wAddr;
						s_nxt.latData = wData;
						s_nxt.remain = s_r.remain - 6'h01;
						if (s_r.remain == 6'h01) begin
							s_nxt.st = ST_BCONF;
						end
					end
				end
			end
			ST_BCONF: begin
				// Only a confirm in the sector, after a full count, starts programming.
				if (cmdWr) begin
					if ((wData == CMD_CONFIRM) && inSector(wAddr, s_r.sector)) begin
						s_nxt.isBuf = 1'b1;
						s_nxt.timer = PROG_LOAD;
						s_nxt.st = ST_BUSY;
					end else begin
						s_nxt.st = ST_ABORT;
					end
				end
			end
			// Only a suspend is heard while the program timer runs.
			ST_BUSY: begin
				if (cmdWr && (wData == CMD_SUSPEND)) begin
					s_nxt.st = ST_SUSP;
				end else if (s_r.timer <= 16'h0001) begin
					progEn = ~s_r.isBuf;
					commitEn = s_r.isBuf;
					s_nxt.latAddr = '0;
					s_nxt.bufValid = '0;
					s_nxt.st = ST_READ;
				end else begin
					s_nxt.timer = s_r.timer - 16'h0001;
				end
			end
			// The timer is frozen until a resume arrives.
			ST_SUSP: begin
				if (cmdWr && (wData == CMD_RESUME)) begin
					s_nxt.st = ST_BUSY;
				end
			end
			// The aborted state holds until the first unlock write arrives.
			ST_ABORT: begin
				if (cmdWr && isCmd(wAddr, wData, CMD_UNLOCK1, OFF_UNLOCK1)) begin
					s_nxt.st = ST_AB1;
				end
			end
			// Anything but the second unlock write keeps the abort.
			ST_AB1: begin
				if (cmdWr) begin
					if (isCmd(wAddr, wData, CMD_UNLOCK2, OFF_UNLOCK2)) begin
						s_nxt.st = ST_AB2;
					end else begin
						s_nxt.st = ST_ABORT;
					end
				end
			end
			// Only the reset command at the unlock offset clears the abort.
			ST_AB2: begin
				if (cmdWr) begin
					if (isCmd(wAddr, wData, CMD_RESET, OFF_UNLOCK1)) begin
						s_nxt.ovfAbort = 1'b0;
						s_nxt.bufValid = '0;
						s_nxt.st = ST_READ;
					end else begin
						s_nxt.st = ST_ABORT;
					end
				end
			end
			default: begin
				s_nxt.st = ST_READ;
			end
		endcase
	end

	// Registers the whole core state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: ST_READ, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Status and read data
	// ****************************************************************

	// Status replaces array data while programming or aborted.
	assign showStatus = (s_r.st == ST_BUSY) || (s_r.st == ST_ABORT) ||
		(s_r.st == ST_AB1) || (s_r.st == ST_AB2);

	// Status word: inverted data bit seven, toggle, timeout, erase toggle, abort.
	always_comb begin
		statusWord = 16'h0000;
		statusWord[DATA_POLLING_BIT] = ~s_r.latData[7] & ~s_r.ovfAbort;
		statusWord[TOGGLE_STATUS_BIT] = s_r.toggle;
		statusWord[TIMEOUT_FLAG_BIT] = 1'b0;
		statusWord[ERASE_TOGGLE_BIT] = 1'b0;
		statusWord[BUFFER_ABORT_FLAG_BIT] = (s_r.st != ST_BUSY);
	end

	// Block status register shows the sequencer's own state.
	always_comb begin
		blockStatus = 32'h0000_0000;
		blockStatus[SR_BUSY] = (s_r.st == ST_BUSY);
		blockStatus[SR_SUSP] = (s_r.st == ST_SUSP);
		blockStatus[SR_ABRT] = showStatus && (s_r.st != ST_BUSY);
		blockStatus[SR_BUFD] = s_r.isBuf;
		blockStatus[SR_REM +: 6] = s_r.remain;
		blockStatus[SR_ST +: 12] = s_r.st;
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		case (regs.rIdx)
			REG_CMD_ADDR: regs.rdata = 32'(s_r.cmdAddr);
			REG_CMD_DATA: regs.rdata = 32'(s_r.cmdData);
			REG_RD_ADDR:  regs.rdata = 32'(s_r.rdAddr);
			REG_RD_DATA:  regs.rdata = showStatus ? 32'(statusWord) : 32'(arrData);
			REG_STATUS:   regs.rdata = blockStatus;
			default:      regs.rdata = 32'h0000_0000;
		endcase
	end
endmodule

// file: shared/fwbp_pkg.sv
// Package: constants and types of the flash word and buffer programming sequencer.
// Behaviour
// - Single word: unlock pair, A0 at 555, data.
// - Every sequence opens with AA@555, 55@2AA.
// - Finished program returns read mode, drops address.
// - Word program reports polling and toggle status.
// - Write buffer holds at most 32 words.
// - Buffer load 25 selects the sector.
// - Fourth cycle carries word count minus one.
// - Count over capacity aborts; polling bit invalid.
// - Load outside selected sector aborts.
// - Load outside start page aborts.
// - Every load decrements counter; last data wins.
// - Count mismatch makes confirm ignored; the code takes an early confirm as a load, and an extra load aborts.
// - Confirm 29 at sector; anything else aborts.
// - After confirm busy, status bits reported.
// - Buffer program honours suspend, resume; ends read.
// - Buffered sequence spans 6 to 37 writes.
// - Unlock pair then F0@555 clears abort.
// - Programming only clears bits: old AND new.
// - While busy only suspend is accepted.
package fwbp_pkg;

	// Command data words and unlock offsets.
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_PROG    = 16'h00a0;
	localparam logic [15:0] CMD_BUFLOAD = 16'h0025;
	localparam logic [15:0] CMD_CONFIRM = 16'h0029;
	localparam logic [15:0] CMD_RESET   = 16'h00f0;
	localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
	localparam logic [15:0] CMD_RESUME  = 16'h0030;
	localparam logic [10:0] OFF_UNLOCK1 = 11'h555;
	localparam logic [10:0] OFF_UNLOCK2 = 11'h2aa;

	// Buffer geometry, array geometry and erased value.
	localparam int          BUF_WORDS   = 32;
	localparam int          PAGE_LSB    = $clog2(BUF_WORDS);
	localparam int          ARR_AW      = 12;
	localparam int          SECT_LSB    = 10;
	localparam logic [15:0] ERASED_WORD = 16'hffff;

	// Register byte offsets on the bus.
	localparam logic [7:0] REG_CMD_ADDR = 8'h00;
	localparam logic [7:0] REG_CMD_DATA = 8'h04;
	localparam logic [7:0] REG_RD_ADDR  = 8'h08;
	localparam logic [7:0] REG_RD_DATA  = 8'h0c;
	localparam logic [7:0] REG_STATUS   = 8'h10;

	// Status word bit positions and block status register fields.
	localparam int DATA_POLLING_BIT      = 7;
	localparam int TOGGLE_STATUS_BIT     = 6;
	localparam int TIMEOUT_FLAG_BIT      = 5;
	localparam int ERASE_TOGGLE_BIT      = 2;
	localparam int BUFFER_ABORT_FLAG_BIT = 1;
	localparam int SR_BUSY = 0;
	localparam int SR_SUSP = 1;
	localparam int SR_ABRT = 2;
	localparam int SR_BUFD = 3;
	localparam int SR_REM  = 8;
	localparam int SR_ST   = 16;

	// Program time and its cycle count at 40 MHz.
	localparam int CLK_PERIOD_NS = 25;
	localparam int PROG_TIME_NS  = 10000;
	localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Sequencer states, one-hot.
	typedef enum logic [11:0] {
		ST_READ   = 12'h001,
		ST_UNLK1  = 12'h002,
		ST_UNLK2  = 12'h004,
		ST_PSETUP = 12'h008,
		ST_BCOUNT = 12'h010,
		ST_BLOAD  = 12'h020,
		ST_BCONF  = 12'h040,
		ST_BUSY   = 12'h080,
		ST_SUSP   = 12'h100,
		ST_ABORT  = 12'h200,
		ST_AB1    = 12'h400,
		ST_AB2    = 12'h800
	} fwbp_state_e;

endpackage

// file: shared/fwbp_reg_if.sv
// Interface: register strobes between the bus slave and the sequencer core.
`timescale 1ns/1ps
interface fwbp_reg_if;
	logic        wrEn;
	logic [7:0]  wIdx;
	logic [31:0] wdata;
	logic        rdEn;
	logic [7:0]  rIdx;
	logic [31:0] rdata;

	modport slave (output wrEn, wIdx, wdata, rdEn, rIdx, input rdata);
	modport core  (input wrEn, wIdx, wdata, rdEn, rIdx, output rdata);
endinterface

// file: src/fwbp_ahb_slave.sv
// AHB-Lite slave with zero wait states that turns transfers into register strobes.
`timescale 1ns/1ps
module fwbp_ahb_slave
	import fwbp_pkg::*;
(
	input  logic        core_clk,
	input  logic        rst_n,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic [31:0] hrdata,
	output logic        hreadyout,
	output logic        hresp,
	fwbp_reg_if.slave   regs
);
	typedef struct packed {
		logic        wrPend;
		logic [7:0]  wIdx;
		logic [31:0] rdata;
	} fwbp_slv_s;

	fwbp_slv_s s_r;
	fwbp_slv_s s_nxt;
	logic      accept;

	// Only whole-word singles are used, so the size is not decoded.
	assign accept = hsel & htrans[1] & hready;

	// Writes wait for their data phase; read data is captured at the address phase.
	always_comb begin
		s_nxt = s_r;
		s_nxt.wrPend = accept & hwrite;
		if (accept & hwrite) begin
			s_nxt.wIdx = haddr[7:0];
		end
		if (accept & ~hwrite) begin
			s_nxt.rdata = regs.rdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Strobes to the core and the fixed OKAY answer.
	assign regs.wrEn  = s_r.wrPend;
	assign regs.wIdx  = s_r.wIdx;
	assign regs.wdata = hwdata;
	assign regs.rdEn  = accept & ~hwrite;
	assign regs.rIdx  = haddr[7:0];
	assign hrdata     = s_r.rdata;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
endmodule

// file: src/fwbp_array.sv
// Flash array held in flip-flops, with single word and page commit ports.
`timescale 1ns/1ps
module fwbp_array
	import fwbp_pkg::*;
#(
	parameter int AW = ARR_AW
) (
	input  logic                              core_clk,
	input  logic                              rst_n,
	input  logic [AW-1:0]                     rdAddr,
	output logic [15:0]                       rdData,
	input  logic                              progEn,
	input  logic [AW-1:0]                     progAddr,
	input  logic [15:0]                       progData,
	input  logic                              commitEn,
	input  logic [AW-1:PAGE_LSB]              commitPage,
	input  logic [BUF_WORDS-1:0][15:0]        bufData,
	input  logic [BUF_WORDS-1:0]              bufValid
);
	typedef struct packed {
		logic [(2**AW)-1:0][15:0] mem;
	} fwbp_arr_s;

	fwbp_arr_s s_r;
	fwbp_arr_s s_nxt;

	// A program cell can only fall from one to zero.
	function automatic logic [15:0] burn(input logic [15:0] oldW, input logic [15:0] newW);
		burn = oldW & newW;
	endfunction

	// Single word program and whole page commit of the valid buffer slots.
	always_comb begin
		s_nxt = s_r;
		if (progEn) begin
			s_nxt.mem[progAddr] = burn(s_r.mem[progAddr], progData);
		end
		if (commitEn) begin
			for (int i = 0; i < BUF_WORDS; i++) begin
				if (bufValid[i]) begin
					s_nxt.mem[{commitPage, PAGE_LSB'(i)}] =
						burn(s_r.mem[{commitPage, PAGE_LSB'(i)}], bufData[i]);
				end
			end
		end
	end

	// The array powers up erased.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= {(2**AW){ERASED_WORD}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdData = s_r.mem[rdAddr];
endmodule

// file: test/fwbp_assertions.sv
// Checker of the bus answer and status register consistency of the sequencer.
`timescale 1ns/1ps
module fwbp_assertions
	import fwbp_pkg::*;
(
	input logic        core_clk,
	input logic        rst_n,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp
);
	// ************************************************************
	// Properties
	// ************************************************************
	// Marks read address phases, and those of the status register.
	logic anyRd;
	logic stRd;
	assign anyRd = hsel & htrans[1] & hready & !hwrite;
	assign stRd  = anyRd & (haddr[7:0] == REG_STATUS);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_ready; hreadyout == 1'b1; endproperty
	a_ready: assert property (p_ready) else $error("Slave inserted a wait state.");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("Slave gave an error response.");
	property p_hold; !anyRd |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("Read data moved without a read.");
	property p_rstzero; $rose(rst_n) |-> hrdata == 32'h0; endproperty
	a_rstzero: assert property (p_rstzero) else $error("Read data not cleared by reset.");
	property p_onehot; stRd |=> $onehot(hrdata[27:16]); endproperty
	a_onehot: assert property (p_onehot) else $error("State field not one-hot.");
	property p_busy; stRd |=> hrdata[SR_BUSY] == hrdata[SR_ST+7]; endproperty
	a_busy: assert property (p_busy) else $error("Busy flag disagrees with state.");
	property p_susp; stRd |=> hrdata[SR_SUSP] == hrdata[SR_ST+8]; endproperty
	a_susp: assert property (p_susp) else $error("Suspend flag disagrees with state.");
	property p_abrt; stRd |=> hrdata[SR_ABRT] == (|hrdata[SR_ST+11:SR_ST+9]); endproperty
	a_abrt: assert property (p_abrt) else $error("Abort flag disagrees with state.");
	property p_rem; stRd |=> hrdata[13:8] <= 6'd32; endproperty
	a_rem: assert property (p_rem) else $error("Remaining count above buffer size.");
endmodule

// file: test/fwbp_host_model.sv
// Host side model: an AHB-Lite master that issues flash command writes.
`timescale 1ns/1ps
module fwbp_host_model
	import fwbp_pkg::*;
(
	input  logic        core_clk,
	input  logic        hready,
	input  logic [31:0] hrdata,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	// ************************************************************
	// Bus and command tasks
	// ************************************************************
	// Idle bus at time zero; the slave stays selected throughout.
	initial begin
		hsel   = 1'b1;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// One word transfer; entered just after a rising edge.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d; // Released data no longer shows the last value.
	endtask

	task automatic bwrite(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic bread(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask

	// One flash write cycle: address register, then data register.
	task automatic flashWr(input logic [11:0] a, input logic [15:0] d);
		bwrite(REG_CMD_ADDR, {20'h0, a});
		bwrite(REG_CMD_DATA, {16'h0, d});
	endtask

	// Unlock pair that opens every sequence.
	task automatic unlock();
		flashWr({1'b0, OFF_UNLOCK1}, CMD_UNLOCK1);
		flashWr({1'b0, OFF_UNLOCK2}, CMD_UNLOCK2);
	endtask

	// Four-cycle single word program.
	task automatic wordProg(input logic [11:0] a, input logic [15:0] d);
		unlock();
		flashWr({1'b0, OFF_UNLOCK1}, CMD_PROG);
		flashWr(a, d);
	endtask
endmodule

// file: test/test_flash_word_and_buffer_program.sv
// Testbench of the flash word and buffer programming sequencer.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module test_flash_word_and_buffer_program
	import fwbp_pkg::*;
;
	// ************************************************************
	// Bench
	// ************************************************************
	logic        core_clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] v;
	logic [15:0] w;
	logic        t;
	int          bad_count = 0;
	int          num_checks = 0;

	// The sequencer under test with a short program time, and its host.
	fwbp_top #(.PROG_CYC_P(40)) dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	fwbp_host_model host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	// Clock at 40 MHz.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Reads the state field of the status register.
	task automatic chkSt(input logic [11:0] st);
		host.bread(REG_STATUS, v);
		`CHK(v[27:16], st)
	endtask

	// Polls until the busy flag drops, bounded.
	task automatic waitIdle();
		for (int i = 0; i < 100; i++) begin
			host.bread(REG_STATUS, v);
			if (v[SR_BUSY] === 1'b0) break;
		end
		`CHK(v[SR_BUSY], 1'b0)
	endtask

	// Reads one array word, one idle cycle after setting the address.
	task automatic rdArr(input logic [11:0] a, input logic [15:0] e);
		host.bwrite(REG_RD_ADDR, {20'h0, a});
		@(posedge core_clk);
		host.bread(REG_RD_DATA, v);
		`CHK(v[15:0], e)
	endtask

	// Cuts a hang short.
	initial begin
		#500000;
		bad_count++;
		complete_run();
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chkSt(ST_READ);
		host.bread(8'h20, v);
		`CHK(v, 32'h0)
		// Word program, polling, toggling, ignored command while busy, AND of data.
		host.wordProg(12'h123, 16'h0f0f);
		host.bread(REG_RD_DATA, v);
		`CHK(v[DATA_POLLING_BIT], 1'b1)
		t = v[TOGGLE_STATUS_BIT];
		host.bread(REG_RD_DATA, v);
		`CHK(v[TOGGLE_STATUS_BIT], ~t)
		host.flashWr(12'h555, CMD_UNLOCK1);
		waitIdle();
		chkSt(ST_READ);
		rdArr(12'h123, 16'h0f0f);
		host.wordProg(12'h123, 16'h3355);
		waitIdle();
		rdArr(12'h123, 16'h0305);
		// Suspend and resume of a running program.
		host.wordProg(12'h200, 16'h1234);
		host.flashWr(12'h200, CMD_SUSPEND);
		host.bread(REG_STATUS, v);
		`CHK(v[SR_SUSP], 1'b1)
		host.flashWr(12'h200, CMD_RESUME);
		waitIdle();
		rdArr(12'h200, 16'h1234);
		// Buffered program of three loads with one location loaded twice.
		host.unlock();
		host.flashWr(12'h440, CMD_BUFLOAD);
		host.flashWr(12'h440, 16'h0002);
		host.bread(REG_STATUS, v);
		`CHK(v[13:8], 6'd3)
		host.bread(REG_CMD_ADDR, v);
		`CHK(v, 32'h0000_0440)
		host.bread(REG_CMD_DATA, v);
		`CHK(v, 32'h0000_0002)
		host.flashWr(12'h440, 16'haaaa);
		host.flashWr(12'h440, 16'h5a5a);
		host.flashWr(12'h441, 16'h0ff0);
		chkSt(ST_BCONF);
		host.flashWr(12'h440, CMD_CONFIRM);
		chkSt(ST_BUSY);
		waitIdle();
		chkSt(ST_READ);
		`CHK(v[SR_BUFD], 1'b1)
		rdArr(12'h440, 16'h5a5a);
		rdArr(12'h441, 16'h0ff0);
		rdArr(12'h442, 16'hffff);
		// Full buffer of 32 ascending loads, confirmed at the last address and polled on the busy flag.
		host.unlock();
		host.flashWr(12'h480, CMD_BUFLOAD);
		host.flashWr(12'h480, 16'h001f);
		host.bread(REG_STATUS, v);
		`CHK(v[13:8], 6'd32)
		for (int i = 0; i < 32; i++) begin
			w = 16'hc300 + 16'(i);
			host.flashWr(12'h480 + 12'(i), w);
		end
		host.flashWr(12'h49f, CMD_CONFIRM);
		waitIdle();
		rdArr(12'h480, 16'hc300);
		rdArr(12'h49f, 16'hc31f);
		host.bread(REG_RD_ADDR, v);
		`CHK(v, 32'h0000_049f)
		// Abort on count over capacity, load outside sector, load outside page and wrong confirm, the sticky abort, then the abort reset.
		for (int k = 0; k < 4; k++) begin
			host.unlock();
			host.flashWr(12'h440, CMD_BUFLOAD);
			host.flashWr(12'h440, (k == 0) ? 16'h0020 : 16'h0001);
			if (k == 1) host.flashWr(12'h040, 16'h0000);
			if (k >= 2) host.flashWr(12'h440, 16'h0000);
			if (k == 2) host.flashWr(12'h460, 16'h0000);
			if (k == 3) host.flashWr(12'h441, 16'h0000);
			if (k == 3) host.flashWr(12'h440, 16'h0000);
			chkSt(ST_ABORT);
			host.bread(REG_RD_DATA, v);
			`CHK(v[BUFFER_ABORT_FLAG_BIT], 1'b1)
			if (k == 0) `CHK(v[DATA_POLLING_BIT], 1'b0)
			if (k == 0) host.wordProg(12'h300, 16'h0000);
			if (k == 0) chkSt(ST_ABORT);
			host.unlock();
			host.flashWr(12'h555, CMD_RESET);
			chkSt(ST_READ);
		end
		complete_run();
	end
endmodule

bind fwbp_top fwbp_assertions chk (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
